// ==== core/system_handler_priority_state.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "shp_defs.svh"
module system_handler_priority_state
  import shp_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input  wire logic              clk,                     // Core clock, 25 MHz
  input  wire logic              reset_n,                 // Async reset, active low
  input  wire logic [ADDR_W-1:0] addr,                    // Register byte address
  input  wire logic [31:0]       wrData,                  // Write data
  input  wire logic              wrStrobe,                // One-cycle write
  input  wire logic              rdStrobe,                // One-cycle read
  output logic      [31:0]       rdData,                  // Read data, next cycle
  input  wire logic [3:0]        pendSetEv,               // Pend request {svc,bus,mem,usg}
  input  wire logic [3:0]        pendClrEv,               // Pend cleared on entry
  input  wire logic [11:0]       actSetEv,                // Handler entry, ctrl bit order
  input  wire logic [11:0]       actClrEv,                // Handler return, ctrl bit order
  output logic      [2:0]        memmanagePriority,       // Memory fault priority
  output logic      [2:0]        busFaultPriority,        // Bus fault priority
  output logic      [2:0]        usageFaultPriority,      // Usage fault priority
  output logic      [2:0]        reservedPriority,        // Slot 3 priority (handler 7)
  output logic      [2:0]        svcPriority,             // Supervisor call priority
  output logic      [2:0]        monitorPriority,         // Debug monitor priority
  output logic      [2:0]        pendsvPriority,          // Pendable service priority
  output logic      [2:0]        tickPriority,            // Tick timer priority
  output logic                   usage_fault_enable,      // Usage fault enabled
  output logic                   bus_fault_enable,        // Bus fault enabled
  output logic                   memmanage_fault_enable,  // Memory fault enabled
  output logic                   svc_pending,             // Supervisor call pended
  output logic                   bus_fault_pending,       // Bus fault pended
  output logic                   memmanage_pending,       // Memory fault pended
  output logic                   usage_fault_pending,     // Usage fault pended
  output logic                   tick_timer_active,       // Tick handler active
  output logic                   pendable_service_active, // Pendable handler active
  output logic                   debug_monitor_active,    // Monitor handler active
  output logic                   svc_active,              // Supervisor handler active
  output logic                   usage_fault_active,      // Usage handler active
  output logic                   bus_fault_active,        // Bus handler active
  output logic                   memmanage_active,        // Memory handler active
  output logic                   irq                      // Level interrupt
);
  localparam int NSLOT = `SHP_SLOT_COUNT;

  reg_sel_t   sel;
  logic [2:0] slotPrio [NSLOT];
  logic [7:0] slotByte [NSLOT];
  logic [31:0] priWord [3];
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic [31:0] hwSet;
  logic [31:0] hwClr;
  logic [3:0]  pendAcc;
  logic [3:0]  stat_q;
  logic [3:0]  mask_q;
  logic [31:0] rdData_q;
  logic [31:0] rdMux;

  // Address decode, unmapped addresses select nothing
  always_comb begin
    sel = SEL_NONE;
    if (addr == ADDR_W'(`SHP_WORD0_ADDR)) begin
      sel = SEL_PRI0;
    end else if (addr == ADDR_W'(`SHP_WORD1_ADDR)) begin
      sel = SEL_PRI1;
    end else if (addr == ADDR_W'(`SHP_WORD2_ADDR)) begin
      sel = SEL_PRI2;
    end else if (addr == ADDR_W'(`SHP_CTRL_ADDR)) begin
      sel = SEL_CTRL;
    end else if (addr == ADDR_W'(`SHP_IRQ_STAT_ADDR)) begin
      sel = SEL_STAT;
    end else if (addr == ADDR_W'(`SHP_IRQ_MASK_ADDR)) begin
      sel = SEL_MASK;
    end
  end

  for (genvar k = 0; k < NSLOT; k++) begin : g_slot
    priority_slot #(
      .IMPL (1'(`SHP_SLOT_IMPL >> k))
    ) u_slot (
      .clk      (clk),
      .reset_n  (reset_n),
      .wrEn     (wrStrobe && (sel == reg_sel_t'(3'(k / 4 + 1)))),
      .wrByte   (wrData[8*(k%4) +: 8]),
      .prio     (slotPrio[k]),
      .slotByte (slotByte[k])
    );
  end

  // Word view of the slot bytes for readback
  for (genvar w = 0; w < 3; w++) begin : g_word
    assign priWord[w] = {slotByte[4*w+3], slotByte[4*w+2],
                         slotByte[4*w+1], slotByte[4*w]};
  end

  assign memmanagePriority  = slotPrio[0];
  assign busFaultPriority   = slotPrio[1];
  assign usageFaultPriority = slotPrio[2];
  assign reservedPriority   = slotPrio[3];
  // handler slots in words 1, 2
  assign svcPriority        = slotPrio[7];
  assign monitorPriority    = slotPrio[8];
  assign pendsvPriority     = slotPrio[10];
  assign tickPriority       = slotPrio[11];

  assign pendAcc = pendSetEv & {1'b1,
                                ctrl_q[`SHP_BUS_ENA_BIT],
                                ctrl_q[`SHP_MEM_ENA_BIT],
                                ctrl_q[`SHP_USG_ENA_BIT]};

  // Hardware set/clear vectors in control bit positions
  assign hwSet = (32'(pendAcc) << `SHP_PEND_LSB)
               | 32'(actSetEv & `SHP_ACT_MASK);
  assign hwClr = (32'(pendClrEv) << `SHP_PEND_LSB)
               | 32'(actClrEv & `SHP_ACT_MASK);

  // Set beats software write and hardware clear
  always_comb begin
    ctrl_d = ctrl_q;
    if (wrStrobe && sel == SEL_CTRL) begin
      ctrl_d = wrData;
    end
    ctrl_d = ((ctrl_d & ~hwClr) | hwSet) & `SHP_CTRL_WMASK;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= `SHP_CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  assign usage_fault_enable     = ctrl_q[`SHP_USG_ENA_BIT];
  assign bus_fault_enable       = ctrl_q[`SHP_BUS_ENA_BIT];
  assign memmanage_fault_enable = ctrl_q[`SHP_MEM_ENA_BIT];
  assign svc_pending            = ctrl_q[15];
  assign bus_fault_pending      = ctrl_q[14];
  assign memmanage_pending      = ctrl_q[13];
  assign usage_fault_pending    = ctrl_q[12];
  assign tick_timer_active       = ctrl_q[11];
  assign pendable_service_active = ctrl_q[10];
  assign debug_monitor_active    = ctrl_q[8];
  assign svc_active              = ctrl_q[7];
  assign usage_fault_active      = ctrl_q[3];
  assign bus_fault_active        = ctrl_q[1];
  assign memmanage_active        = ctrl_q[0];

  // Sticky event status, write one to clear, new event wins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stat_q <= `SHP_EVT_RESET;
    end else if (wrStrobe && sel == SEL_STAT) begin
      stat_q <= (stat_q & ~wrData[`SHP_EVT_W-1:0]) | pendAcc;
    end else begin
      stat_q <= stat_q | pendAcc;
    end
  end

  // Interrupt mask, same layout as status
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mask_q <= `SHP_EVT_RESET;
    end else if (wrStrobe && sel == SEL_MASK) begin
      mask_q <= wrData[`SHP_EVT_W-1:0];
    end
  end

  assign irq = |(stat_q & mask_q);

  // Readback mux, unmapped reads return zero
  always_comb begin
    rdMux = 32'h0000_0000;
    case (sel)
      SEL_PRI0: rdMux = priWord[0];
      SEL_PRI1: rdMux = priWord[1];
      SEL_PRI2: rdMux = priWord[2];
      SEL_CTRL: rdMux = ctrl_q;
      SEL_STAT: rdMux = 32'(stat_q);
      SEL_MASK: rdMux = 32'(mask_q);
      default:  rdMux = 32'h0000_0000;
    endcase
  end

  // Data valid only in the cycle after the read strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdData_q <= 32'h0000_0000;
    end else begin
      rdData_q <= rdStrobe ? rdMux : 32'h0000_0000;
    end
  end

  assign rdData = rdData_q;

  // Checks on the register behaviour
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_slot_bits_kept: assert property (
    wrStrobe && sel == SEL_PRI0 |=> memmanagePriority == $past(wrData[7:5])
  ) else $error("memory fault priority not taken from bits 7:5");

  a_prio_low_zero: assert property (
    rdStrobe && (sel == SEL_PRI0 || sel == SEL_PRI2)
      |=> (rdData & 32'h1F1F_1F1F) == 32'h0000_0000
  ) else $error("unimplemented priority bits read nonzero");

  a_usage_prio_field: assert property (
    rdStrobe && sel == SEL_PRI0 |=> rdData[23:21] == usageFaultPriority
  ) else $error("usage fault priority misplaced");

  a_bus_prio_field: assert property (
    wrStrobe && sel == SEL_PRI0 ##1 !wrStrobe ##1 rdStrobe && sel == SEL_PRI0
      |=> rdData[15:13] == $past(wrData[15:13], 3)
  ) else $error("bus fault priority readback wrong");

  a_mem_prio_hold: assert property (
    !(wrStrobe && sel == SEL_PRI0) |=> $stable(memmanagePriority)
  ) else $error("memory fault priority changed without write");

  a_enable_write: assert property (
    wrStrobe && sel == SEL_CTRL |=>
      {usage_fault_enable, bus_fault_enable, memmanage_fault_enable}
        == $past(wrData[18:16])
  ) else $error("fault enables not written");

  a_pend_gated: assert property (
    !bus_fault_enable && !bus_fault_pending && !(wrStrobe && sel == SEL_CTRL)
      |=> !bus_fault_pending
  ) else $error("bus fault pended while disabled");

  a_pend_set_wins: assert property (
    pendSetEv[3] |=> svc_pending && stat_q[3]
  ) else $error("supervisor call pend lost");

  a_active_set: assert property (
    actSetEv[1] |=> bus_fault_active
  ) else $error("bus fault active flag not set");

  a_svc_active_clear: assert property (
    actClrEv[7] && !actSetEv[7] && !(wrStrobe && sel == SEL_CTRL)
      |=> !svc_active
  ) else $error("supervisor active flag not cleared");

  a_svc_word_place: assert property (
    rdStrobe && sel == SEL_PRI1 |=> rdData == {svcPriority, 29'h0}
  ) else $error("supervisor priority word wrong");

  a_ctrl_reserved: assert property (
    rdStrobe && sel == SEL_CTRL |=> (rdData & ~`SHP_CTRL_WMASK) == 32'h0
  ) else $error("reserved control bits read nonzero");

  a_irq_level: assert property (
    wrStrobe && sel == SEL_STAT && pendAcc == 4'h0
      && (stat_q & ~wrData[`SHP_EVT_W-1:0]) == 4'h0 |=> !irq
  ) else $error("interrupt still high after status cleared");

  a_read_window: assert property (
    !rdStrobe |=> rdData == 32'h0000_0000
  ) else $error("read data outside its cycle");

  a_usage_prio_write: assert property (
    wrStrobe && sel == SEL_PRI0 |=> usageFaultPriority == $past(wrData[23:21])
  ) else $error("usage fault priority not taken from bits 23:21");

  a_bus_prio_write: assert property (
    wrStrobe && sel == SEL_PRI0 |=> busFaultPriority == $past(wrData[15:13])
  ) else $error("bus fault priority not taken from bits 15:13");

  a_svc_prio_write: assert property (
    wrStrobe && sel == SEL_PRI1 |=> svcPriority == $past(wrData[31:29])
  ) else $error("supervisor priority not taken from top byte");

  a_word2_prio_write: assert property (
    wrStrobe && sel == SEL_PRI2 |=> {tickPriority, pendsvPriority, monitorPriority}
      == {$past(wrData[31:29]), $past(wrData[23:21]), $past(wrData[7:5])}
  ) else $error("word2 priorities not taken from their bytes");

  a_word2_gap_zero: assert property (
    rdStrobe && sel == SEL_PRI2 |=> rdData[15:8] == 8'h00
  ) else $error("unimplemented word2 byte reads nonzero");

  a_word2_prio_hold: assert property (
    !(wrStrobe && sel == SEL_PRI2)
      |=> $stable({tickPriority, pendsvPriority, monitorPriority})
  ) else $error("word2 priorities changed without write");

  a_svc_prio_hold: assert property (
    !(wrStrobe && sel == SEL_PRI1) |=> $stable(svcPriority)
  ) else $error("supervisor priority changed without write");

  a_enable_hold: assert property (
    !(wrStrobe && sel == SEL_CTRL)
      |=> $stable({usage_fault_enable, bus_fault_enable, memmanage_fault_enable})
  ) else $error("fault enables changed without write");

  a_usage_pend_gated: assert property (
    !usage_fault_enable && !usage_fault_pending && !(wrStrobe && sel == SEL_CTRL)
      |=> !usage_fault_pending
  ) else $error("usage fault pended while disabled");

  a_mem_pend_gated: assert property (
    !memmanage_fault_enable && !memmanage_pending && !(wrStrobe && sel == SEL_CTRL)
      |=> !memmanage_pending
  ) else $error("memory fault pended while disabled");

  a_pend_clear: assert property (
    pendClrEv[1] && !(pendSetEv[1] && memmanage_fault_enable)
      && !(wrStrobe && sel == SEL_CTRL) |=> !memmanage_pending
  ) else $error("memory fault pend not cleared on entry");

  a_mem_active_set: assert property (
    actSetEv[0] |=> memmanage_active
  ) else $error("memory fault active flag not set");

  a_ctrl_write: assert property (
    wrStrobe && sel == SEL_CTRL && pendSetEv == 4'h0 && pendClrEv == 4'h0
      && actSetEv == 12'h000 && actClrEv == 12'h000
      |=> ctrl_q == ($past(wrData) & `SHP_CTRL_WMASK)
  ) else $error("control word not written through its mask");

  a_tick_active_hold: assert property (
    !actSetEv[11] && !actClrEv[11] && !(wrStrobe && sel == SEL_CTRL)
      |=> $stable(tick_timer_active)
  ) else $error("tick active flag moved without cause");

  c_fault_pended: cover property (
    memmanage_fault_enable && pendSetEv[1] ##1 memmanage_pending
  );
  c_irq_cleared: cover property (
    irq ##1 wrStrobe && sel == SEL_STAT ##1 !irq
  );
  c_tick_prio_read: cover property (
    wrStrobe && sel == SEL_PRI2 ##2 rdStrobe && sel == SEL_PRI2
  );
  c_set_beats_clear: cover property (
    wrStrobe && sel == SEL_STAT && |pendAcc
  );
endmodule
`default_nettype wire

// ==== core/shp_defs.svh ====
`ifndef SHP_DEFS_SVH
`define SHP_DEFS_SVH

// Register byte addresses
`define SHP_WORD0_ADDR     32'hE000_ED18
`define SHP_WORD1_ADDR     32'hE000_ED1C
`define SHP_WORD2_ADDR     32'hE000_ED20
`define SHP_CTRL_ADDR      32'hE000_ED24
`define SHP_IRQ_STAT_ADDR  32'hE000_ED80
`define SHP_IRQ_MASK_ADDR  32'hE000_ED84

// Priority slots: 12 slots for handlers 4 to 15
`define SHP_SLOT_COUNT     12
`define SHP_SLOT_IMPL      12'hD8F
`define SHP_PRI_MSB        7
`define SHP_PRI_LSB        5
`define SHP_PRI_RESET      3'h0

// Control/state field positions
`define SHP_USG_ENA_BIT    18
`define SHP_BUS_ENA_BIT    17
`define SHP_MEM_ENA_BIT    16
`define SHP_PEND_LSB       12
`define SHP_CTRL_WMASK     32'h0007_FD8B
`define SHP_CTRL_RESET     32'h0000_0000
`define SHP_ACT_MASK       12'hD8B

// Interrupt status/mask layout: {svc, bus, mem, usage}
`define SHP_EVT_W          4
`define SHP_EVT_RESET      4'h0
`endif

// ==== core/shp_pkg.sv ====
package shp_pkg;
  // Register selected by the bus address
  typedef enum logic [2:0] {
    SEL_NONE  = 3'b000,
    SEL_PRI0  = 3'b001,
    SEL_PRI1  = 3'b010,
    SEL_PRI2  = 3'b011,
    SEL_CTRL  = 3'b100,
    SEL_STAT  = 3'b101,
    SEL_MASK  = 3'b110
  } reg_sel_t;
endpackage

// ==== core/priority_slot.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "shp_defs.svh"
module priority_slot #(
  parameter bit IMPL = 1'b1
) (
  input  wire logic       clk,      // Core clock
  input  wire logic       reset_n,  // Async reset, active low
  input  wire logic       wrEn,     // Write this slot
  input  wire logic [7:0] wrByte,   // Byte lane data
  output logic      [2:0] prio,     // Implemented priority bits
  output logic      [7:0] slotByte  // Byte as software reads it
);
  logic [2:0] prio_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prio_q <= `SHP_PRI_RESET;
    end else if (wrEn && IMPL) begin
      prio_q <= wrByte[`SHP_PRI_MSB:`SHP_PRI_LSB];
    end
  end

  assign prio     = IMPL ? prio_q : 3'h0;
  assign slotByte = {prio, 5'h00};
endmodule
`default_nettype wire

// ==== tb/system_handler_priority_state_test.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "shp_defs.svh"
module system_handler_priority_state_test;
  import shp_pkg::*;

  logic        clk;
  logic        reset_n;
  logic [31:0] addr;
  logic [31:0] wrData;
  logic        wrStrobe;
  logic        rdStrobe;
  logic [31:0] rdData;
  logic [3:0]  pendSetEv;
  logic [3:0]  pendClrEv;
  logic [11:0] actSetEv;
  logic [11:0] actClrEv;
  logic [2:0]  memPri, busPri, usgPri, resPri, svcPri, monPri, psvPri, tickPri;
  logic        usgEna, busEna, memEna, svcPend, busPend, memPend, usgPend;
  logic        tickAct, psvAct, monAct, svcAct, usgAct, busAct, memAct, irq;
  int          numErrors;
  int          checksDone;
  logic [31:0] rv;

  system_handler_priority_state dut_u (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .pendSetEv(pendSetEv), .pendClrEv(pendClrEv), .actSetEv(actSetEv),
    .actClrEv(actClrEv), .memmanagePriority(memPri), .busFaultPriority(busPri),
    .usageFaultPriority(usgPri), .reservedPriority(resPri), .svcPriority(svcPri),
    .monitorPriority(monPri), .pendsvPriority(psvPri), .tickPriority(tickPri),
    .usage_fault_enable(usgEna), .bus_fault_enable(busEna),
    .memmanage_fault_enable(memEna), .svc_pending(svcPend),
    .bus_fault_pending(busPend), .memmanage_pending(memPend),
    .usage_fault_pending(usgPend), .tick_timer_active(tickAct),
    .pendable_service_active(psvAct), .debug_monitor_active(monAct),
    .svc_active(svcAct), .usage_fault_active(usgAct), .bus_fault_active(busAct),
    .memmanage_active(memAct), .irq(irq)
  );

  // 25 MHz core clock
  initial clk = 1'b0;
  always #20 clk = ~clk;

  // Single verdict point for normal end and watchdog alike
  task automatic report_and_stop();
    $display("Checks made: %0d, mismatches: %0d", checksDone, numErrors);
    if (numErrors == 0 && checksDone > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Compare one word-sized result
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      numErrors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One-cycle write; effects land on the strobe's edge
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    wrStrobe <= 1'b1;
    addr     <= a;
    wrData   <= d;
    @(posedge clk);
    wrStrobe <= 1'b0;
    #1;
  endtask

  // One-cycle read; data stands only in the following cycle
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk);
    rdStrobe <= 1'b1;
    addr     <= a;
    @(posedge clk);
    rdStrobe <= 1'b0;
    #1;
    d = rdData;
  endtask

  // Event pulse lasting a single cycle
  task automatic ev(input logic [3:0] ps, input logic [3:0] pc,
                    input logic [11:0] as, input logic [11:0] ac);
    @(posedge clk);
    pendSetEv <= ps;
    pendClrEv <= pc;
    actSetEv  <= as;
    actClrEv  <= ac;
    @(posedge clk);
    pendSetEv <= 4'h0;
    pendClrEv <= 4'h0;
    actSetEv  <= 12'h000;
    actClrEv  <= 12'h000;
    #1;
  endtask

  // Watchdog sized well above the 87 cycles the tests need
  initial begin
    #(40 * 5000);
    numErrors++;
    $display("ERROR watchdog expected finish seen hang");
    report_and_stop();
  end

  // Priority table: address, written value, value read back
  logic [31:0] pA [6] = '{`SHP_WORD0_ADDR, `SHP_WORD1_ADDR, `SHP_WORD2_ADDR,
                          `SHP_WORD2_ADDR, `SHP_WORD2_ADDR, `SHP_WORD0_ADDR};
  logic [31:0] pW [6] = '{32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
                          32'h1F1F_1F1F, 32'h4000_0040, 32'h00A0_6020};
  logic [31:0] pE [6] = '{32'hE0E0_E0E0, 32'hE000_0000, 32'hE0E0_00E0,
                          32'h0000_0000, 32'h4000_0040, 32'h00A0_6020};
  logic [31:0] rA [6] = '{`SHP_WORD0_ADDR, `SHP_WORD1_ADDR, `SHP_WORD2_ADDR,
                          `SHP_CTRL_ADDR, `SHP_IRQ_STAT_ADDR, `SHP_IRQ_MASK_ADDR};

  // Main sequence
  initial begin
    reset_n   = 1'b0;
    addr      = 32'h0000_0000;
    wrData    = 32'h0000_0000;
    wrStrobe  = 1'b0;
    rdStrobe  = 1'b0;
    pendSetEv = 4'h0;
    pendClrEv = 4'h0;
    actSetEv  = 12'h000;
    actClrEv  = 12'h000;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    foreach (rA[i]) begin
      rd(rA[i], rv);
      chk("reset word", 32'h0000_0000, rv); // reset zero
    end
    // Priority words: only bits 7..5 of implemented slots hold
    foreach (pA[i]) begin
      wr(pA[i], pW[i]);
      rd(pA[i], rv);
      chk("priority word", pE[i], rv); // slot layout
    end
    // Read data has gone back to zero one cycle later
    @(posedge clk);
    #1;
    chk("rdData idle", 32'h0000_0000, rdData); // read data one cycle
    chk("fault prios", 32'h0000_0159, {20'h0, resPri, usgPri, busPri, memPri});
    chk("word2 prios", 32'h0000_0417, {20'h0, tickPri, psvPri, monPri, svcPri}); // slots
    // Unmapped place reads zero and disturbs nothing
    wr(32'hE000_ED28, 32'hFFFF_FFFF);
    rd(32'hE000_ED28, rv);
    chk("unmapped", 32'h0000_0000, rv); // no aliasing
    rd(`SHP_WORD0_ADDR, rv);
    chk("word0 kept", 32'h00A0_6020, rv); // writes ignored
    // Control/state: every writable bit, then cleared again
    wr(`SHP_CTRL_ADDR, 32'hFFFF_FFFF);
    rd(`SHP_CTRL_ADDR, rv);
    chk("ctrl ones", 32'h0007_FD8B, rv); // writable bits
    chk("ctrl ports", 32'h0000_3FFF, {18'h0, usgEna, busEna, memEna, svcPend, busPend, memPend,
        usgPend, tickAct, psvAct, monAct, svcAct, usgAct, busAct, memAct});
    wr(`SHP_CTRL_ADDR, 32'h0000_0000);
    rd(`SHP_CTRL_ADDR, rv);
    chk("ctrl zero", 32'h0000_0000, rv); // writes clear
    // Memory fault pend dropped while disabled
    wr(`SHP_IRQ_MASK_ADDR, 32'h0000_000F);
    ev(4'h2, 4'h0, 12'h000, 12'h000);
    chk("pend disabled", 32'h0000_0000, {31'h0, memPend | irq}); // enable gates
    wr(`SHP_CTRL_ADDR, 32'h0001_0000);
    ev(4'h2, 4'h0, 12'h000, 12'h000);
    chk("pend enabled", 32'h0000_0003, {30'h0, memPend, irq}); // pended
    rd(`SHP_IRQ_STAT_ADDR, rv);
    chk("status", 32'h0000_0002, rv); // event status
    wr(`SHP_IRQ_STAT_ADDR, 32'h0000_0002);
    chk("irq cleared", 32'h0000_0000, {31'h0, irq}); // status cleared
    rd(`SHP_CTRL_ADDR, rv);
    chk("ctrl pend", 32'h0001_2000, rv); // flag stays
    ev(4'h0, 4'h2, 12'h000, 12'h000);
    chk("pend cleared", 32'h0000_0000, {31'h0, memPend}); // clear on entry
    // Supervisor call pend needs no enable; mask gates irq
    wr(`SHP_IRQ_MASK_ADDR, 32'h0000_0000);
    ev(4'h8, 4'h0, 12'h000, 12'h000);
    chk("svc masked", 32'h0000_0002, {30'h0, svcPend, irq}); // masked out
    wr(`SHP_IRQ_MASK_ADDR, 32'h0000_0008);
    chk("svc unmasked", 32'h0000_0001, {31'h0, irq}); // level irq
    wr(`SHP_IRQ_STAT_ADDR, 32'h0000_0008);
    chk("svc cleared", 32'h0000_0000, {31'h0, irq}); // write one clears
    // Handler entry and return move only the active flags
    ev(4'h0, 4'h0, 12'hFFF, 12'h000);
    rd(`SHP_CTRL_ADDR, rv);
    chk("act set", 32'h0001_8D8B, rv); // active flags
    ev(4'h0, 4'h0, 12'h000, 12'hFFF);
    rd(`SHP_CTRL_ADDR, rv);
    chk("act clr", 32'h0001_8000, rv); // return clears
    // Set beats clear when both land in one cycle
    ev(4'h2, 4'h2, 12'h001, 12'h001); // set and clear together
    chk("set wins", 32'h0000_0003, {30'h0, memPend, memAct}); // set wins
    report_and_stop();
  end
endmodule
`default_nettype wire
